//--- logic/sip_map.svh
`ifndef SIP_MAP_SVH
`define SIP_MAP_SVH
// ******************************************
// register offsets (byte addresses)
// ******************************************
`define SIP_OFF_CFG    12'h000
`define SIP_OFF_SYNC   12'h004
`define SIP_OFF_DISC   12'h008
`define SIP_OFF_WIDE   12'h00C
`define SIP_OFF_START  12'h010
`define SIP_OFF_RATE   12'h014
`define SIP_OFF_STS    12'h018
`define SIP_OFF_MASK   12'h01C
`define SIP_OFF_ARB    12'h020
`define SIP_OFF_SPIN   12'h024
// ******************************************
// field positions and reset values
// ******************************************
`define SIP_CFG_RESTORE 31
`define SIP_RST_CFG    32'h0000_0077
`define SIP_RST_SYNC   16'hFFFF
`define SIP_RST_DISC   16'hFFFF
`define SIP_RST_WIDE   16'hFFFF
`define SIP_RST_START  16'h0000
`define SIP_RST_RATE   32'h0000_0000
`define SIP_OWN_ID_DFL 4'h7
`define SIP_STS_ARB    0
`define SIP_STS_PAR    1
`define SIP_STS_SPIN   2
`define SIP_STS_NEG    3
`define SIP_START_UNIT 8'h1B
`endif

//--- logic/sip_pkg.sv
`default_nettype none
package sip_pkg;
    typedef struct packed {
        logic [14:12] boot_lun;
        logic [3:0]   boot_tgt;
        logic         ultra;
        logic         term_hi;
        logic         term_lo;
        logic         par_en;
        logic [3:0]   own_id;
    } sip_cfg_s;
    typedef struct packed {
        logic       sync_init;
        logic       sync;
        logic [8:0] rate_x100k;
        logic       wide_init;
        logic       disc;
    } sip_neg_s;
    typedef enum logic [1:0] {SU_IDLE, SU_SCAN, SU_WAIT} sip_su_e;
endpackage : sip_pkg
`default_nettype wire

//--- logic/sip_policy.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`include "sip_map.svh"
`default_nettype none
module sip_policy (
    input  wire logic        i_ref_clk,      // 25 MHz clock
    input  wire logic        i_rst,          // async reset, high
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb enable
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic             pready,         // apb ready
    output logic      [31:0] prdata,         // apb read data
    output logic             pslverr,        // apb error
    output logic             o_irq,          // interrupt level
    input  wire logic        i_wide_adapter, // 16-bit adapter
    input  wire logic [15:0] i_arb_req,      // contending ids
    output logic      [3:0]  o_arb_win_id,   // arbitration winner
    output logic             o_arb_win_vld,  // winner valid
    output logic             o_par_chk_en,   // parity check enable
    input  wire logic        i_par_err,      // raw parity error pulse
    output logic             o_term_lo,      // low byte terminators
    output logic             o_term_hi,      // high byte terminators
    input  wire logic        i_neg_req,      // negotiation needed
    input  wire logic [3:0]  i_neg_tgt,      // target concerned
    input  wire logic        i_tgt_sync_req, // target began sync
    input  wire logic        i_tgt_sync_ok,  // target accepted sync
    input  wire logic [1:0]  i_tgt_rate,     // target rate index
    input  wire logic        i_tgt_wide,     // target is 16-bit
    output sip_pkg::sip_neg_s o_neg,         // negotiated policy
    output logic             o_su_valid,     // start unit command
    output logic      [3:0]  o_su_tgt,       // its target
    output logic      [2:0]  o_su_lun,       // its lun
    output logic      [7:0]  o_su_opcode,    // command opcode
    input  wire logic        i_su_done       // target answered
);
    // ******************************************
    // apb decode
    // ******************************************
    sip_pkg::sip_cfg_s cfg_q;
    logic [15:0] sync_q, disc_q, wide_q, start_q;
    logic [31:0] rate_q, sts_q, mask_q;
    logic        wr, rst_dflt, hit;
    logic [3:0]  set;

    assign wr       = psel & penable & pwrite;
    assign rst_dflt = wr && paddr == `SIP_OFF_CFG
                      && pwdata[`SIP_CFG_RESTORE];
    // no wait states: every access completes in its first access cycle
    assign pready   = 1'b1;
    always_comb begin
        hit = 1'b1;
        prdata = 32'h0000_0000;
        unique case (paddr)
            `SIP_OFF_CFG:   prdata = {17'h00000, cfg_q};
            `SIP_OFF_SYNC:  prdata = {16'h0000, sync_q};
            `SIP_OFF_DISC:  prdata = {16'h0000, disc_q};
            `SIP_OFF_WIDE:  prdata = {16'h0000, wide_q};
            `SIP_OFF_START: prdata = {16'h0000, start_q};
            `SIP_OFF_RATE:  prdata = rate_q;
            `SIP_OFF_STS:   prdata = sts_q;
            `SIP_OFF_MASK:  prdata = mask_q;
            `SIP_OFF_ARB:   prdata = {27'h0000000, o_arb_win_vld,
                                      o_arb_win_id};
            `SIP_OFF_SPIN:  prdata = {27'h0000000, o_su_tgt,
                                      o_su_valid};
            default:        hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~hit;

    // ******************************************
    // adapter configuration
    // ******************************************
    logic cfg_wr;
    assign cfg_wr = wr && paddr == `SIP_OFF_CFG && !pwdata[`SIP_CFG_RESTORE];
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_q <= 15'(`SIP_RST_CFG);
        end else if (rst_dflt) begin
            cfg_q <= 15'(`SIP_RST_CFG);
        end else if (cfg_wr) begin
            // ids beyond the narrow range are refused on a narrow adapter
            if (i_wide_adapter || !pwdata[3])
                cfg_q.own_id <= pwdata[3:0];
            if (i_wide_adapter || !pwdata[11])
                cfg_q.boot_tgt <= pwdata[11:8];
            cfg_q.boot_lun <= pwdata[14:12];
            cfg_q.par_en   <= pwdata[4];
            cfg_q.ultra    <= pwdata[7];
            // low on with high off would leave the upper byte floating
            if (!(pwdata[5] && !pwdata[6])) begin
                cfg_q.term_lo <= pwdata[5];
                cfg_q.term_hi <= pwdata[6];
            end
        end
    end
    assign o_par_chk_en = cfg_q.par_en;
    assign o_term_lo    = cfg_q.term_lo;
    assign o_term_hi    = cfg_q.term_hi;

    // ******************************************
    // per-target flags
    // ******************************************
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_q  <= `SIP_RST_SYNC;
            disc_q  <= `SIP_RST_DISC;
            wide_q  <= `SIP_RST_WIDE;
            start_q <= `SIP_RST_START;
            rate_q  <= `SIP_RST_RATE;
        end else if (rst_dflt) begin
            // restore is kept out of the async branch so reset stays pure
            sync_q  <= `SIP_RST_SYNC;
            disc_q  <= `SIP_RST_DISC;
            wide_q  <= `SIP_RST_WIDE;
            start_q <= `SIP_RST_START;
            rate_q  <= `SIP_RST_RATE;
        end else if (wr) begin
            if (paddr == `SIP_OFF_SYNC)  sync_q  <= pwdata[15:0];
            if (paddr == `SIP_OFF_DISC)  disc_q  <= pwdata[15:0];
            if (paddr == `SIP_OFF_WIDE)  wide_q  <= pwdata[15:0];
            if (paddr == `SIP_OFF_START) start_q <= pwdata[15:0];
            if (paddr == `SIP_OFF_RATE)  rate_q  <= pwdata;
        end
    end

    // ******************************************
    // interrupts
    // ******************************************
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sts_q  <= 32'h0000_0000;
            mask_q <= 32'h0000_0000;
        end else begin
            // a new event wins over a clear in the same cycle
            sts_q <= (sts_q & ~((wr && paddr == `SIP_OFF_STS) ? pwdata
                     : 32'h0000_0000)) | {28'h0000000, set};
            if (wr && paddr == `SIP_OFF_MASK) mask_q <= pwdata;
        end
    end
    assign o_irq = |(sts_q & mask_q);

    // ******************************************
    // arbitration
    // ******************************************
    // wide ids 0-7 fold above 8-15 so one compare serves both widths
    function automatic logic [3:0] rank(input logic [3:0] id,
                                        input logic wide);
        rank = wide ? (id[3] ? {1'b0, id[2:0]} : {1'b1, id[2:0]})
                    : id;
    endfunction : rank
    logic [3:0] win_id, win_rank;
    logic       win_vld;
    always_comb begin
        win_id = 4'h0;
        win_rank = 4'h0;
        win_vld = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (i_arb_req[i] && (i_wide_adapter || i < 8) &&
                (!win_vld || rank(4'(i), i_wide_adapter) > win_rank)) begin
                win_vld  = 1'b1;
                win_id   = 4'(i);
                win_rank = rank(4'(i), i_wide_adapter);
            end
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arb_win_id  <= 4'h0;
            o_arb_win_vld <= 1'b0;
        end else begin
            o_arb_win_id  <= win_id;
            o_arb_win_vld <= win_vld;
        end
    end

    // ******************************************
    // negotiation policy
    // ******************************************
    logic [1:0] cap, agreed;
    logic       do_sync;
    assign cap     = rate_q[{i_neg_tgt, 1'b0} +: 2];
    // larger index is slower; the slower of the two offers is agreed
    assign agreed  = (i_tgt_rate > cap) ? i_tgt_rate : cap;
    assign do_sync = (sync_q[i_neg_tgt] && i_tgt_sync_ok)
                     || i_tgt_sync_req;
    function automatic logic [8:0] rate_tab(input logic ultra,
                                            input logic [1:0] idx);
        unique case (idx)
            2'h0: rate_tab = ultra ? 9'h190 : 9'h0C8;
            2'h1: rate_tab = ultra ? 9'h140 : 9'h0A0;
            2'h2: rate_tab = ultra ? 9'h10C : 9'h086;
            2'h3: rate_tab = ultra ? 9'h0C8 : 9'h064;
        endcase
    endfunction : rate_tab
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_neg <= '0;
        end else if (i_neg_req) begin
            o_neg.sync_init  <= sync_q[i_neg_tgt];
            o_neg.sync       <= do_sync;
            o_neg.rate_x100k <= do_sync ? rate_tab(cfg_q.ultra, agreed)
                                        : 9'h000;
            o_neg.wide_init  <= i_wide_adapter && wide_q[i_neg_tgt]
                                && i_tgt_wide;
            o_neg.disc       <= disc_q[i_neg_tgt];
        end
    end

    // ******************************************
    // start unit sequencing
    // ******************************************
    sip_pkg::sip_su_e su_q;
    logic [4:0] ptr_q;
    logic       boot_q, spin_go, su_end;
    assign spin_go = wr && paddr == `SIP_OFF_SPIN && pwdata[0];
    assign su_end  = su_q == sip_pkg::SU_SCAN &&
                     ptr_q == (i_wide_adapter ? 5'h10 : 5'h08);
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            su_q     <= sip_pkg::SU_IDLE;
            ptr_q    <= 5'h00;
            boot_q   <= 1'b0;
            o_su_tgt <= 4'h0;
            o_su_lun <= 3'h0;
        end else begin
            unique case (su_q)
                sip_pkg::SU_IDLE: if (spin_go) begin
                    ptr_q <= 5'h00;
                    if (start_q[cfg_q.boot_tgt]) begin
                        su_q     <= sip_pkg::SU_WAIT;
                        boot_q   <= 1'b1;
                        o_su_tgt <= cfg_q.boot_tgt;
                        o_su_lun <= cfg_q.boot_lun;
                    end else begin
                        su_q <= sip_pkg::SU_SCAN;
                    end
                end
                sip_pkg::SU_SCAN: if (su_end) begin
                    su_q <= sip_pkg::SU_IDLE;
                end else if (start_q[ptr_q[3:0]] &&
                             ptr_q[3:0] != cfg_q.boot_tgt) begin
                    su_q     <= sip_pkg::SU_WAIT;
                    boot_q   <= 1'b0;
                    o_su_tgt <= ptr_q[3:0];
                    o_su_lun <= 3'h0;
                end else begin
                    ptr_q <= ptr_q + 5'h01;
                end
                sip_pkg::SU_WAIT: if (i_su_done) begin
                    su_q <= sip_pkg::SU_SCAN;
                    if (!boot_q) ptr_q <= ptr_q + 5'h01;
                end
            endcase
        end
    end
    // the wait for an answer has no limit; a silent drive stalls the scan
    assign o_su_valid  = su_q == sip_pkg::SU_WAIT;
    assign o_su_opcode = `SIP_START_UNIT;
    assign set = {i_neg_req, su_end, i_par_err & cfg_q.par_en, win_vld};

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    parity_gate_a: assert property (!cfg_q.par_en |=>
        !($rose(sts_q[`SIP_STS_PAR]))) else $error("parity flag gated");
    parity_set_a: assert property (i_par_err && cfg_q.par_en |=>
        sts_q[`SIP_STS_PAR]) else $error("parity flag lost");
    arb_narrow_a: assert property (!i_wide_adapter && !$past(i_wide_adapter)
        && o_arb_win_vld |-> !o_arb_win_id[3])
        else $error("narrow winner out of range");
    arb_top_a: assert property (i_arb_req[7] |=>
        o_arb_win_id == 4'h7) else $error("id seven lost");
    arb_weak_a: assert property (i_wide_adapter && i_arb_req[8] &&
        (i_arb_req & 16'hFEFF) != 16'h0000 |=> o_arb_win_id != 4'h8)
        else $error("id eight won");
    term_legal_a: assert property (!(o_term_lo && !o_term_hi))
        else $error("illegal termination");
    wide_gate_a: assert property (i_neg_req && !i_tgt_wide |=>
        !o_neg.wide_init) else $error("wide to narrow target");
    async_mode_a: assert property (i_neg_req && !i_tgt_sync_req &&
        !(sync_q[i_neg_tgt] && i_tgt_sync_ok) |=>
        !o_neg.sync && o_neg.rate_x100k == 9'h000)
        else $error("sync without negotiation");
    restore_a: assert property (rst_dflt |=>
        cfg_q == 15'(`SIP_RST_CFG) && start_q == `SIP_RST_START &&
        sync_q == `SIP_RST_SYNC) else $error("defaults not restored");
    boot_first_a: assert property (su_q == sip_pkg::SU_IDLE && spin_go
        && start_q[cfg_q.boot_tgt] |=> o_su_valid &&
        o_su_tgt == $past(cfg_q.boot_tgt) &&
        o_su_lun == $past(cfg_q.boot_lun)) else $error("boot not first");
    irq_level_a: assert property (wr && paddr == `SIP_OFF_STS &&
        (sts_q & ~pwdata) == 32'h0000_0000 && set == 4'h0 |=> !o_irq)
        else $error("irq stuck after clear");
    sync_start_a: assert property (i_neg_req &&
        sync_q[i_neg_tgt] && i_tgt_sync_ok |=> o_neg.sync_init && o_neg.sync)
        else $error("sync not started");
    tgt_answer_a: assert property (i_neg_req &&
        i_tgt_sync_req |=> o_neg.sync && o_neg.rate_x100k != 9'h000)
        else $error("target sync ignored");
    disc_deny_a: assert property (i_neg_req &&
        !disc_q[i_neg_tgt] |=> !o_neg.disc)
        else $error("disconnect not forbidden");
    rate_cap_a: assert property (i_neg_req && cap == 2'h2 &&
        i_tgt_rate != 2'h3 && !cfg_q.ultra && i_tgt_sync_req |=>
        o_neg.rate_x100k == 9'h086) else $error("rate above cap");
    scan_order_a: assert property (su_q == sip_pkg::SU_SCAN &&
        !su_end && start_q[ptr_q[3:0]] && ptr_q[3:0] != cfg_q.boot_tgt |=>
        o_su_valid && {1'b0, o_su_tgt} == $past(ptr_q))
        else $error("start unit out of order");
    narrow_id_a: assert property (cfg_wr && !i_wide_adapter &&
        pwdata[3] |=> cfg_q.own_id == $past(cfg_q.own_id))
        else $error("narrow id accepted");

    // ******************************************
    // coverage
    // ******************************************
    spin_c: cover property (o_su_valid && !boot_q ##[1:20] su_end);
    neg_c: cover property (i_neg_req && i_tgt_sync_req && !sync_q[i_neg_tgt]);
    arb_c: cover property (i_wide_adapter && i_arb_req[15] && i_arb_req[0]);
    restore_c: cover property (rst_dflt ##1 cfg_q.own_id == 4'h7);
    boot_c: cover property (o_su_valid && boot_q && i_su_done);
endmodule : sip_policy
`default_nettype wire

//--- tb/sip_tgt_model.sv
`default_nettype none
module sip_tgt_model (
    input  wire logic        i_ref_clk,   // clock
    input  wire logic        i_rst,       // async reset, high
    input  wire logic        i_su_valid,  // start unit pending
    input  wire logic [3:0]  i_su_tgt,    // addressed id
    input  wire logic [7:0]  i_su_opcode, // opcode on offer
    input  wire logic [3:0]  i_delay,     // spin-up cycles
    output logic             o_su_done,   // response pulse
    output logic      [15:0] o_order,     // ids answered, newest low
    output logic      [3:0]  o_cnt,       // answers given
    output logic             o_op_bad     // wrong opcode seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q;
    // *****************************
    // spin-up response
    // *****************************
    // a drive answers once per command and only after spinning up
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_su_done <= 1'b0;
            wait_q    <= 4'h0;
            o_order   <= 16'h0000;
            o_cnt     <= 4'h0;
            o_op_bad  <= 1'b0;
        end else if (i_su_valid && o_su_done) begin
            o_su_done <= 1'b0;
            wait_q    <= 4'h0;
            o_order   <= {o_order[11:0], i_su_tgt};
            o_cnt     <= o_cnt + 4'h1;
            if (i_su_opcode !== 8'h1B) begin
                o_op_bad <= 1'b1;
            end
        end else if (i_su_valid) begin
            if (wait_q == i_delay) begin
                o_su_done <= 1'b1;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            o_su_done <= 1'b0;
            wait_q    <= 4'h0;
        end
    end
endmodule : sip_tgt_model
`default_nettype wire

//--- tb/tb.sv
`include "sip_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk, i_rst, psel, penable, pwrite, pready, pslverr, o_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic i_wide_adapter, o_arb_win_vld, o_par_chk_en, i_par_err, rerr;
    logic [15:0] i_arb_req, order;
    logic [3:0] o_arb_win_id, i_neg_tgt, o_su_tgt, cnt;
    logic o_term_lo, o_term_hi, i_neg_req, i_tgt_sync_req, i_tgt_sync_ok;
    logic [1:0] i_tgt_rate;
    logic i_tgt_wide, o_su_valid, i_su_done, op_bad;
    sip_pkg::sip_neg_s o_neg;
    logic [2:0] o_su_lun;
    logic [7:0] o_su_opcode;
    int error_cnt, n_checks, k;
    logic [15:0] areq [6] = '{16'h0081, 16'h0006, 16'h8002,
                              16'h8001, 16'h8100, 16'h0100};
    logic [4:0] aexp [6] = '{5'h17, 5'h12, 5'h11, 5'h10, 5'h1F, 5'h18};
    logic [8:0] rt0 [4] = '{9'd200, 9'd160, 9'd134, 9'd100};
    logic [8:0] rt1 [4] = '{9'd400, 9'd320, 9'd268, 9'd200};
    logic [31:0] cv [3] = '{32'h57, 32'h37, 32'h17};
    logic [1:0] te [3] = '{2'b01, 2'b01, 2'b00};

    sip_policy u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .o_irq(o_irq),
        .i_wide_adapter(i_wide_adapter), .i_arb_req(i_arb_req),
        .o_arb_win_id(o_arb_win_id), .o_arb_win_vld(o_arb_win_vld),
        .o_par_chk_en(o_par_chk_en), .i_par_err(i_par_err),
        .o_term_lo(o_term_lo), .o_term_hi(o_term_hi), .i_neg_req(i_neg_req),
        .i_neg_tgt(i_neg_tgt), .i_tgt_sync_req(i_tgt_sync_req),
        .i_tgt_sync_ok(i_tgt_sync_ok), .i_tgt_rate(i_tgt_rate),
        .i_tgt_wide(i_tgt_wide), .o_neg(o_neg), .o_su_valid(o_su_valid),
        .o_su_tgt(o_su_tgt), .o_su_lun(o_su_lun), .o_su_opcode(o_su_opcode),
        .i_su_done(i_su_done));
    sip_tgt_model u_tgt (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_su_valid(o_su_valid), .i_su_tgt(o_su_tgt),
        .i_su_opcode(o_su_opcode), .i_delay(4'h3), .o_su_done(i_su_done),
        .o_order(order), .o_cnt(cnt), .o_op_bad(op_bad));

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    // ***************************************
    // shared tasks
    // ***************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one transfer; read data is taken at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge i_ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge i_ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            error_cnt++;
            finish_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so registered results have settled for the caller
        @(posedge i_ref_clk);
    endtask : apb
    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rdchk
    task automatic neg(input logic [3:0] t, input logic sr, so, tw,
                       input logic [1:0] r, input logic [11:0] e);
        @(posedge i_ref_clk);
        i_neg_req <= 1'b1;
        i_neg_tgt <= t;
        i_tgt_sync_req <= sr;
        i_tgt_sync_ok <= so;
        i_tgt_wide <= tw;
        i_tgt_rate <= r;
        @(posedge i_ref_clk);
        i_neg_req <= 1'b0;
        @(posedge i_ref_clk);
        chk("neg", {20'h0, e}, {20'h0, o_neg.sync, o_neg.rate_x100k,
            o_neg.wide_init, o_neg.disc});
    endtask : neg
    task automatic perr;
        @(posedge i_ref_clk);
        i_par_err <= 1'b1;
        @(posedge i_ref_clk);
        i_par_err <= 1'b0;
    endtask : perr
    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {i_wide_adapter, i_arb_req, i_par_err, i_neg_req, i_neg_tgt} = '0;
        {i_tgt_sync_req, i_tgt_sync_ok, i_tgt_rate, i_tgt_wide} = '0;
        error_cnt = 0;
        n_checks = 0;
        i_rst = 1'b1;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rdchk("cfg", `SIP_OFF_CFG, 32'h77);
        rdchk("sync", `SIP_OFF_SYNC, 32'hFFFF);
        rdchk("disc", `SIP_OFF_DISC, 32'hFFFF);
        rdchk("wide", `SIP_OFF_WIDE, 32'hFFFF);
        rdchk("start", `SIP_OFF_START, 32'h0);
        chk("par", 1, o_par_chk_en);
        chk("term", 3, {o_term_lo, o_term_hi});
        rdchk("unmapped", 12'h040, 32'h0);
        chk("slverr", 1, rerr);
        $display("test reset done");
        for (k = 0; k < 6; k++) begin
            i_wide_adapter <= (k > 2);
            i_arb_req <= areq[k];
            repeat (2) @(posedge i_ref_clk);
            chk("arb", aexp[k], {o_arb_win_vld, o_arb_win_id});
        end
        i_arb_req <= 16'h0;
        apb(1'b1, `SIP_OFF_MASK, 32'h1);
        chk("irq on", 1, o_irq);
        apb(1'b1, `SIP_OFF_STS, 32'h1);
        perr();
        rdchk("sts par", `SIP_OFF_STS, 32'h2);
        chk("irq masked", 0, o_irq);
        apb(1'b1, `SIP_OFF_STS, 32'h2);
        apb(1'b1, `SIP_OFF_CFG, 32'h67);
        chk("par off", 0, o_par_chk_en);
        perr();
        rdchk("sts nopar", `SIP_OFF_STS, 32'h0);
        $display("test arb irq done");
        for (k = 0; k < 3; k++) begin
            apb(1'b1, `SIP_OFF_CFG, cv[k]);
            chk("term", te[k], {o_term_lo, o_term_hi});
        end
        i_wide_adapter <= 1'b0;
        apb(1'b1, `SIP_OFF_CFG, 32'h797C);
        rdchk("narrow ids", `SIP_OFF_CFG, 32'h7077);
        i_wide_adapter <= 1'b1;
        apb(1'b1, `SIP_OFF_CFG, 32'h7977);
        rdchk("wide ids", `SIP_OFF_CFG, 32'h7977);
        $display("test cfg done");
        for (k = 0; k < 4; k++) begin
            neg(4'h3, 0, 1, 1, k, {1'b1, rt0[k], 2'b11});
        end
        chk("sync init", 1, o_neg.sync_init);
        apb(1'b1, `SIP_OFF_CFG, 32'h79F7);
        for (k = 0; k < 4; k++) begin
            neg(4'h3, 0, 1, 1, k, {1'b1, rt1[k], 2'b11});
        end
        apb(1'b1, `SIP_OFF_CFG, 32'h7977);
        apb(1'b1, `SIP_OFF_SYNC, 32'hFFF7);
        neg(4'h3, 0, 1, 1, 0, {1'b0, 9'd0, 2'b11});
        chk("sync init off", 0, o_neg.sync_init);
        neg(4'h3, 1, 0, 1, 0, {1'b1, 9'd200, 2'b11});
        apb(1'b1, `SIP_OFF_RATE, 32'h80);
        neg(4'h3, 1, 0, 1, 1, {1'b1, 9'd134, 2'b11});
        neg(4'h3, 1, 0, 1, 3, {1'b1, 9'd100, 2'b11});
        neg(4'h4, 0, 1, 0, 0, {1'b1, 9'd200, 2'b01});
        i_wide_adapter <= 1'b0;
        neg(4'h4, 0, 1, 1, 0, {1'b1, 9'd200, 2'b01});
        apb(1'b1, `SIP_OFF_DISC, 32'hFFEF);
        neg(4'h4, 0, 1, 1, 0, {1'b1, 9'd200, 2'b00});
        $display("test neg done");
        i_wide_adapter <= 1'b1;
        apb(1'b1, `SIP_OFF_START, 32'h1204);
        apb(1'b1, `SIP_OFF_SPIN, 32'h1);
        chk("su lun", 7, o_su_lun);
        chk("su boot", 9, o_su_tgt);
        for (k = 0; k < 60; k++) begin
            apb(1'b0, `SIP_OFF_STS, 32'h0);
            if (rdat[2] === 1'b1) break;
        end
        chk("su done", 1, rdat[2]);
        chk("su order", 32'h092C, {16'h0, order});
        chk("su cnt", 3, cnt);
        chk("su op", 0, op_bad);
        apb(1'b1, `SIP_OFF_CFG, 32'h8000_0000);
        rdchk("rst cfg", `SIP_OFF_CFG, 32'h77);
        rdchk("rst start", `SIP_OFF_START, 32'h0);
        rdchk("rst rate", `SIP_OFF_RATE, 32'h0);
        $display("test spin restore done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
